// ---- inc/mdp_cfg.svh ----
// constants for the memory map decoder and protection checker
`ifndef MDP_CFG_SVH
`define MDP_CFG_SVH
`define MDP_ADDR_W 26
`define MDP_PHYS_PAGES 128
`define MDP_PPN_W 7
`define MDP_LOG_PAGES_MAX 8192
`define MDP_LPN_W 13
`define MDP_MAX_OFS_W 15
`define MDP_TOP_HI 25
`define MDP_TOP_LO 22
`define MDP_SPEED_W 2
`define MDP_ROM_SPEED_RST 2'h0
`define MDP_PSIZE_RST 2'h0
`define MDP_OSMODE_RST 1'h0
`define MDP_DMA_W 17
`define MDP_CTRL_SEL_BIT 17
`define MDP_CTRL_PSIZE_LO 2
`define MDP_CTRL_LROM_LO 4
`define MDP_CTRL_HROM_LO 6
`define MDP_CTRL_OS_BIT 12
`define MDP_DMA_SEL_LO 17
`define MDP_XL_PPN_LO 0
`define MDP_XL_PROT_LO 8
`define MDP_XL_LPN_LO 10
`endif

// ---- inc/mdp_pkg.sv ----
// types for the memory map decoder and protection checker
package mdp_pkg;
  typedef enum logic [2:0] {
    MDP_TGT_NONE,
    MDP_TGT_LRAM,
    MDP_TGT_PRAM,
    MDP_TGT_IO,
    MDP_TGT_ROM,
    MDP_TGT_VID,
    MDP_TGT_REG,
    MDP_TGT_XLAT
  } mdp_target_type;
  typedef enum logic {MDP_ROLE_SLAVE, MDP_ROLE_MASTER} mdp_role_type;
  typedef enum logic {MDP_IO_IDLE, MDP_IO_WAIT} mdp_io_state_type;
endpackage

// ---- core/mdp_xlat.sv ----
// logical to physical page translator table
`timescale 1ns/1ps
`include "mdp_cfg.svh"
module mdp_xlat #(
  parameter int LOG_PAGES = `MDP_LOG_PAGES_MAX
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // programming port
  input wire logic i_wr,
  input wire logic [`MDP_LPN_W-1:0] i_wr_lpn,
  input wire logic [`MDP_PPN_W-1:0] i_wr_ppn,
  input wire logic [1:0] i_wr_prot,
  // lookup port
  input wire logic [`MDP_LPN_W-1:0] i_lpn,
  output logic o_hit,
  output logic [`MDP_PPN_W-1:0] o_ppn,
  output logic [1:0] o_prot
);
  initial begin
    if (LOG_PAGES != `MDP_LOG_PAGES_MAX) $error("mdp_xlat: LOG_PAGES must be 8192");
  end
  // entries are not cleared at power on, only the valid bits
  logic [`MDP_PPN_W-1:0] ppn_mem [LOG_PAGES];
  logic [1:0] prot_mem [LOG_PAGES];
  logic [LOG_PAGES-1:0] valid_reg;
  // table writes, any time
  always_ff @(posedge i_ref_clk) begin
    if (i_wr) begin
      ppn_mem[i_wr_lpn] <= i_wr_ppn;
      prot_mem[i_wr_lpn] <= i_wr_prot;
    end
  end
  // valid bits
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      valid_reg <= '0;
    end else if (i_wr) begin
      valid_reg[i_wr_lpn] <= 1'b1;
    end
  end
  // combinational lookup
  assign o_hit = valid_reg[i_lpn];
  assign o_ppn = ppn_mem[i_lpn];
  assign o_prot = prot_mem[i_lpn];
endmodule

// ---- core/mdp_decode.sv ----
// memory map decoder, protection checker and role latch
// Summary of operation
// - supervisor input high permits any address in the map
// - supervisor-only control bit selects middle mode; privileged only for logical RAM
// - user mode: only prot 0 logical pages, reads of prot 1 pages, and ROM reads
// - insufficient privilege raises abort and suppresses the target access
// - 128 physical pages; page size 4/8/16/32 KB selectable, alters DRAM muxing
// - byte/word input latched at reset release: 1 master, 0 slave
// - slave acts only as DRAM driver; master handles DMA and I/O
// - 26 address bits decoded; supervisor-only regions need supervisor mode
// - 0000000h-1FFFFFFh is logical RAM; page count follows page size
// - logical page translated; missing mapping aborts, DRAM not activated
// - mapping not initialised; software programs it, any time
// - 2000000h-2FFFFFFh physical pages in order, supervisor only, repeating
// - supervisor access 3000000h-33FFFFFh requests I/O cycle and stops clocks
// - I/O cycle ends on first edge with request and grant both low
// - reads 3400000h-3FFFFFFh select ROM; low and high ROM own speeds
// - reset sets both ROM speeds to slowest
// - supervisor write 3400000h-35FFFFFh pulses video write strobe
// - 3600000h-37FFFFFh writes program DMA generators and control via address
// - DMA generators hold physical addresses for video, cursor, sound
// - supervisor writes 3800000h-3FFFFFFh program translator entries via address
// - reset sets page size to 4 KB
// - reset clears middle privilege mode
`timescale 1ns/1ps
`include "mdp_cfg.svh"
module mdp_decode #(
  parameter int ADDR_W = `MDP_ADDR_W
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // processor cycle
  input wire logic i_mem_req,
  input wire logic i_write,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_supervisor_mode_in,
  input wire logic i_byte_word_n,
  // i/o controller handshake
  input wire logic i_io_cycle_grant_n,
  output logic o_io_cycle_request_n,
  output logic o_clk_stop,
  // target selects and abort
  output logic o_abort_out,
  output logic o_dram_sel,
  output logic [`MDP_PPN_W+`MDP_MAX_OFS_W-1:0] o_dram_addr,
  output logic o_rom_sel,
  output logic o_rom_high,
  output logic [`MDP_SPEED_W-1:0] o_rom_speed,
  output logic o_video_write_strobe_n,
  // configuration state
  output logic o_master,
  output logic o_middle_privilege_mode,
  output logic [1:0] o_page_size,
  output logic [`MDP_DMA_W-1:0] o_dma_vid_addr,
  output logic [`MDP_DMA_W-1:0] o_dma_cur_addr,
  output logic [`MDP_DMA_W-1:0] o_dma_snd_addr
);
  initial begin
    if (ADDR_W != `MDP_ADDR_W) $error("mdp_decode: ADDR_W must be 26");
  end

  // synchronised pins
  logic sv_s1_reg, sv_reg, bw_s1_reg, bw_reg, gnt_s1_reg, gnt_n_reg;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sv_s1_reg <= 1'b0;
      sv_reg <= 1'b0;
      gnt_s1_reg <= 1'b1;
      gnt_n_reg <= 1'b1;
    end else begin
      sv_s1_reg <= i_supervisor_mode_in;
      sv_reg <= sv_s1_reg;
      gnt_s1_reg <= i_io_cycle_grant_n;
      gnt_n_reg <= gnt_s1_reg;
    end
  end
  // role pin synchroniser runs through reset so the level held before release is seen
  always_ff @(posedge i_ref_clk) begin
    bw_s1_reg <= i_byte_word_n;
    bw_reg <= bw_s1_reg;
  end

  // role capture on first edge after reset release
  logic role_done_reg;
  mdp_pkg::mdp_role_type role_reg;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      role_done_reg <= 1'b0;
      role_reg <= mdp_pkg::MDP_ROLE_MASTER;
    end else if (!role_done_reg) begin
      role_done_reg <= 1'b1;
      role_reg <= bw_reg ? mdp_pkg::MDP_ROLE_MASTER : mdp_pkg::MDP_ROLE_SLAVE;
    end
  end
  wire is_master = (role_reg == mdp_pkg::MDP_ROLE_MASTER);

  // region decode by top address bits
  wire [3:0] top = i_addr[`MDP_TOP_HI:`MDP_TOP_LO];
  wire in_lram = (i_addr[25] == 1'b0);
  wire in_pram = (i_addr[25:24] == 2'h2);
  wire in_io = (top == 4'hc);
  wire in_low = (top == 4'hd); // 3400000h-37fffffh
  wire in_hrom = (i_addr[25:23] == 3'h7);
  wire in_vid = in_low && (i_addr[21] == 1'b0);
  wire in_reg = in_low && (i_addr[21] == 1'b1);
  wire in_rom = in_low || in_hrom;

  // privilege
  logic os_reg;
  wire sv = sv_reg;
  wire mid = os_reg && !sv;

  // translator lookup, page number from page size
  logic [1:0] psize_reg;
  logic [`MDP_LPN_W-1:0] lpn;
  logic [`MDP_MAX_OFS_W-1:0] ofs;
  always_comb begin
    lpn = '0;
    ofs = '0;
    case (psize_reg)
      2'h0: begin
        lpn = i_addr[24:12];
        ofs = {3'h0, i_addr[11:0]};
      end
      2'h1: begin
        lpn = {1'h0, i_addr[24:13]};
        ofs = {2'h0, i_addr[12:0]};
      end
      2'h2: begin
        lpn = {2'h0, i_addr[24:14]};
        ofs = {1'h0, i_addr[13:0]};
      end
      default: begin
        lpn = {3'h0, i_addr[24:15]};
        ofs = i_addr[14:0];
      end
    endcase
  end
  // physical page for physically mapped RAM, repeating image
  logic [`MDP_PPN_W-1:0] pram_ppn;
  always_comb begin
    case (psize_reg)
      2'h0: pram_ppn = i_addr[18:12];
      2'h1: pram_ppn = i_addr[19:13];
      2'h2: pram_ppn = i_addr[20:14];
      default: pram_ppn = i_addr[21:15];
    endcase
  end

  wire xl_hit;
  wire [`MDP_PPN_W-1:0] xl_ppn;
  wire [1:0] xl_prot;
  wire xl_wr;
  mdp_xlat u_xlat (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_wr(xl_wr),
    .i_wr_lpn(i_addr[`MDP_XL_LPN_LO+`MDP_LPN_W-1:`MDP_XL_LPN_LO]),
    .i_wr_ppn(i_addr[`MDP_XL_PPN_LO+`MDP_PPN_W-1:`MDP_XL_PPN_LO]),
    .i_wr_prot(i_addr[`MDP_XL_PROT_LO+1:`MDP_XL_PROT_LO]),
    .i_lpn(lpn),
    .o_hit(xl_hit),
    .o_ppn(xl_ppn),
    .o_prot(xl_prot)
  );

  // logical page permission: prot 0 all, 1 mid+sv read/write user read, 2 sv read/write mid read, 3 sv only
  logic lram_ok;
  always_comb begin
    if (sv) begin
      lram_ok = 1'b1;
    end else if (mid) begin
      lram_ok = (xl_prot != 2'h3) && !(xl_prot == 2'h2 && i_write);
    end else begin
      lram_ok = (xl_prot == 2'h0) || (xl_prot == 2'h1 && !i_write);
    end
  end

  // one outcome per access: select or abort, neither for slave access outside RAM
  wire sel_lram = in_lram && xl_hit && lram_ok;
  wire sel_pram = in_pram && sv;
  wire sel_io = in_io && sv && is_master;
  wire sel_rom = in_rom && !i_write && is_master;
  wire sel_vid = in_vid && i_write && sv && is_master;
  wire sel_reg = in_reg && i_write && sv;
  assign xl_wr = i_mem_req && in_hrom && i_write && sv;
  wire slave_quiet = !is_master && !(in_lram || in_pram);
  wire granted = sel_lram || sel_pram || sel_io || sel_rom || sel_vid || sel_reg || xl_wr;
  wire abort_now = i_mem_req && !granted && !slave_quiet;

  // outputs: combinational selects, same-cycle abort
  assign o_abort_out = abort_now;
  assign o_dram_sel = i_mem_req && (sel_lram || sel_pram) && !abort_now;
  assign o_dram_addr = sel_lram ? {xl_ppn, ofs} : {pram_ppn, ofs};
  assign o_rom_sel = i_mem_req && sel_rom;
  assign o_rom_high = in_hrom;
  assign o_video_write_strobe_n = !(i_mem_req && sel_vid);

  // control register and dma generators, data in address bits
  logic [`MDP_SPEED_W-1:0] lrom_spd_reg, hrom_spd_reg;
  logic [`MDP_DMA_W-1:0] dvid_reg, dcur_reg, dsnd_reg;
  wire reg_wr = i_mem_req && sel_reg;
  wire ctrl_wr = reg_wr && i_addr[`MDP_CTRL_SEL_BIT] && i_addr[`MDP_CTRL_SEL_BIT+2];
  wire [1:0] dsel = i_addr[`MDP_DMA_SEL_LO+1:`MDP_DMA_SEL_LO];
  wire dma_wr = reg_wr && !i_addr[`MDP_CTRL_SEL_BIT+2];
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      psize_reg <= `MDP_PSIZE_RST;
      os_reg <= `MDP_OSMODE_RST;
      lrom_spd_reg <= `MDP_ROM_SPEED_RST;
      hrom_spd_reg <= `MDP_ROM_SPEED_RST;
    end else if (ctrl_wr) begin
      psize_reg <= i_addr[`MDP_CTRL_PSIZE_LO+1:`MDP_CTRL_PSIZE_LO];
      lrom_spd_reg <= i_addr[`MDP_CTRL_LROM_LO+1:`MDP_CTRL_LROM_LO];
      hrom_spd_reg <= i_addr[`MDP_CTRL_HROM_LO+1:`MDP_CTRL_HROM_LO];
      os_reg <= i_addr[`MDP_CTRL_OS_BIT];
    end
  end
  // dma address generators
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dvid_reg <= '0;
      dcur_reg <= '0;
      dsnd_reg <= '0;
    end else if (dma_wr && is_master) begin
      if (dsel == 2'h0) dvid_reg <= i_addr[`MDP_DMA_W-1:0];
      else if (dsel == 2'h1) dcur_reg <= i_addr[`MDP_DMA_W-1:0];
      else if (dsel == 2'h2) dsnd_reg <= i_addr[`MDP_DMA_W-1:0];
    end
  end
  assign o_rom_speed = in_hrom ? hrom_spd_reg : lrom_spd_reg;
  assign o_middle_privilege_mode = os_reg;
  assign o_page_size = psize_reg;
  assign o_master = is_master;
  assign o_dma_vid_addr = dvid_reg;
  assign o_dma_cur_addr = dcur_reg;
  assign o_dma_snd_addr = dsnd_reg;

  // i/o cycle: request held until request and grant both low on an edge
  mdp_pkg::mdp_io_state_type io_state_reg, io_state_next;
  always_comb begin
    io_state_next = io_state_reg;
    case (io_state_reg)
      mdp_pkg::MDP_IO_IDLE: if (i_mem_req && sel_io) io_state_next = mdp_pkg::MDP_IO_WAIT;
      default: if (!gnt_n_reg) io_state_next = mdp_pkg::MDP_IO_IDLE;
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      io_state_reg <= mdp_pkg::MDP_IO_IDLE;
    end else begin
      io_state_reg <= io_state_next;
    end
  end
  wire io_wait = (io_state_reg == mdp_pkg::MDP_IO_WAIT);
  assign o_io_cycle_request_n = !io_wait;
  assign o_clk_stop = io_wait;

  // assertions
  property p_abort_excl;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_abort_out |-> (o_io_cycle_request_n && !o_dram_sel && !o_rom_sel && o_video_write_strobe_n);
  endproperty
  a_abort_excl: assert property (p_abort_excl) else $error("abort with a select");
  property p_user_io;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_mem_req && in_io && !sv && is_master) |-> o_abort_out;
  endproperty
  a_user_io: assert property (p_user_io) else $error("user i/o not aborted");
  property p_io_start;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_mem_req && in_io && sv && is_master && !io_wait) |=> !o_io_cycle_request_n;
  endproperty
  a_io_start: assert property (p_io_start) else $error("i/o request missing");
  property p_io_end;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (io_wait && !gnt_n_reg) |=> o_io_cycle_request_n;
  endproperty
  a_io_end: assert property (p_io_end) else $error("i/o cycle not ended");
  property p_rom_read;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_mem_req && in_rom && !i_write && is_master) |-> (o_rom_sel && !o_abort_out);
  endproperty
  a_rom_read: assert property (p_rom_read) else $error("rom read refused");
  property p_user_pram;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_mem_req && in_pram && !sv) |-> (o_abort_out && !o_dram_sel);
  endproperty
  a_user_pram: assert property (p_user_pram) else $error("user physical ram");
  property p_unmapped;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_mem_req && in_lram && !xl_hit) |-> (o_abort_out && !o_dram_sel);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped page used");
  property p_vid_user;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_mem_req && in_vid && i_write && !sv) |-> (o_video_write_strobe_n && o_abort_out);
  endproperty
  a_vid_user: assert property (p_vid_user) else $error("user video write");
  property p_sv_any;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_mem_req && sv && is_master && !in_lram) |-> !o_abort_out;
  endproperty
  a_sv_any: assert property (p_sv_any) else $error("supervisor aborted");
endmodule

// ---- dv/mdp_ioc_model.sv ----
// i/o controller model that answers the cycle request with a grant
`timescale 1ns/1ps
module mdp_ioc_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // handshake with the decoder
  input wire logic i_io_cycle_request_n,
  input wire logic [3:0] i_delay,
  output logic o_io_cycle_grant_n
);
  logic [3:0] wait_reg;
  // grant after the chosen delay, hold it until the request goes away
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_reg <= 4'h0;
      o_io_cycle_grant_n <= 1'h1;
    end else if (i_io_cycle_request_n) begin
      wait_reg <= 4'h0;
      o_io_cycle_grant_n <= 1'h1;
    end else if (wait_reg == i_delay) begin
      o_io_cycle_grant_n <= 1'h0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

// ---- dv/tb.sv ----
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
module tb;
  logic clk, rst_b, req, wr, sup, bw, grant_n, rq_n, stop, abort, dsel, rsel;
  logic rhigh, vid_n, master, mid;
  logic [25:0] addr;
  logic [21:0] daddr;
  logic [1:0] speed, psize;
  logic [16:0] dv, dc, ds;
  logic [3:0] dly;
  logic [9:0] snap;
  logic [14:0] osnap;
  int fails, compares, cycles, n;

  // device under test
  mdp_decode mdp_decode_i (.i_ref_clk(clk), .i_rst_b(rst_b), .i_mem_req(req),
    .i_write(wr), .i_addr(addr), .i_supervisor_mode_in(sup), .i_byte_word_n(bw),
    .i_io_cycle_grant_n(grant_n), .o_io_cycle_request_n(rq_n), .o_clk_stop(stop),
    .o_abort_out(abort), .o_dram_sel(dsel), .o_dram_addr(daddr), .o_rom_sel(rsel),
    .o_rom_high(rhigh), .o_rom_speed(speed), .o_video_write_strobe_n(vid_n),
    .o_master(master), .o_middle_privilege_mode(mid), .o_page_size(psize),
    .o_dma_vid_addr(dv), .o_dma_cur_addr(dc), .o_dma_snd_addr(ds));

  // i/o controller on the far side
  mdp_ioc_model mdp_ioc_model_i (.i_ref_clk(clk), .i_rst_b(rst_b),
    .i_io_cycle_request_n(rq_n), .i_delay(dly), .o_io_cycle_grant_n(grant_n));

  // 25 MHz clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      give_verdict;
    end
  end

  // counts and verdict, then stop
  task automatic give_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // compare one value
  task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one processor cycle; exp is {abort, dram, rom, video strobe_n}
  task automatic acc(input logic w, input logic [25:0] a, input logic [3:0] exp);
    @(posedge clk);
    req <= 1'h1;
    wr <= w;
    addr <= a;
    @(negedge clk);
    snap = {rhigh, speed, daddr[21:15]};
    osnap = daddr[14:0];
    ck({abort, dsel, rsel, vid_n}, exp);
    @(posedge clk);
    req <= 1'h0;
    // registered state written at that edge is looked at once settled
    @(negedge clk);
  endtask

  // supervisor level change, waits out the input synchroniser
  task automatic setsup(input logic v);
    @(posedge clk);
    sup <= v;
    repeat (3) @(posedge clk);
  endtask

  // hold reset two cycles, release and settle
  task automatic reset_run;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // i/o cycle with a grant after d cycles
  task automatic io_run(input logic [3:0] d);
    @(posedge clk);
    dly <= d;
    acc(1'h0, 26'h3000000, 4'h1);
    @(negedge clk);
    ck({rq_n, stop}, 2'h1);
    n = 0;
    while (rq_n !== 1'h1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    // grant seen two edges late through the synchroniser, request drops one edge after
    ck(n, d + 3);
    ck(stop, 1'h0);
  endtask

  // main sequence
  initial begin
    rst_b = 1'h0;
    req = 1'h0;
    wr = 1'h0;
    addr = 26'h0;
    sup = 1'h0;
    bw = 1'h1;
    dly = 4'h0;
    reset_run;
    ck({rq_n, stop, master, mid, psize}, 6'h28);
    acc(1'h0, 26'h0001000, 4'h9);
    acc(1'h0, 26'h3400000, 4'h3);
    ck(snap[8:7], 2'h0);
    acc(1'h1, 26'h3400000, 4'h9);
    acc(1'h0, 26'h2000000, 4'h9);
    acc(1'h0, 26'h3000000, 4'h9);
    ck(rq_n, 1'h1);
    setsup(1'h1);
    acc(1'h1, 26'h3800405, 4'h1);
    acc(1'h1, 26'h3800b06, 4'h1);
    acc(1'h1, 26'h3800e07, 4'h1);
    acc(1'h1, 26'h3801108, 4'h1);
    acc(1'h1, 26'h3fffc7f, 4'h1);
    acc(1'h0, 26'h0002000, 4'h5);
    ck(snap[6:0], 7'h06);
    acc(1'h0, 26'h1ffffff, 4'h5);
    ck(snap[6:0], 7'h7f);
    ck(osnap, 15'h0fff);
    acc(1'h0, 26'h0005000, 4'h9);
    acc(1'h0, 26'h2005000, 4'h5);
    ck(snap[6:0], 7'h05);
    acc(1'h0, 26'h2080000, 4'h5);
    ck(snap[6:0], 7'h00);
    acc(1'h1, 26'h3400000, 4'h0);
    acc(1'h1, 26'h35fffff, 4'h0);
    acc(1'h0, 26'h3ffffff, 4'h3);
    ck(snap[9:7], 3'h4);
    acc(1'h1, 26'h3600abc, 4'h1);
    ck(dv, 17'h00abc);
    acc(1'h1, 26'h3620123, 4'h1);
    ck(dc, 17'h00123);
    acc(1'h1, 26'h365ff00, 4'h1);
    ck(ds, 17'h1ff00);
    io_run(4'h0);
    io_run(4'h6);
    acc(1'h1, 26'h36a1000, 4'h1);
    ck(mid, 1'h1);
    setsup(1'h0);
    acc(1'h0, 26'h0003000, 4'h5);
    acc(1'h1, 26'h0003000, 4'h9);
    acc(1'h0, 26'h0002000, 4'h9);
    acc(1'h0, 26'h2000000, 4'h9);
    acc(1'h1, 26'h36a0000, 4'h9);
    ck(mid, 1'h1);
    setsup(1'h1);
    acc(1'h1, 26'h36a009c, 4'h1);
    ck({mid, psize}, 3'h3);
    setsup(1'h0);
    acc(1'h1, 26'h0008000, 4'h5);
    acc(1'h0, 26'h0020000, 4'h5);
    acc(1'h1, 26'h0020000, 4'h9);
    acc(1'h0, 26'h0018000, 4'h9);
    acc(1'h0, 26'h3400000, 4'h3);
    ck(snap[9:7], 3'h1);
    acc(1'h0, 26'h3800000, 4'h3);
    ck(snap[9:7], 3'h6);
    acc(1'h1, 26'h3800000, 4'h9);
    @(posedge clk);
    bw <= 1'h0;
    @(posedge clk);
    rst_b <= 1'h0;
    reset_run;
    ck({master, mid, psize}, 4'h0);
    setsup(1'h1);
    acc(1'h0, 26'h3000000, 4'h1);
    @(negedge clk);
    ck(rq_n, 1'h1);
    acc(1'h0, 26'h3400000, 4'h1);
    acc(1'h0, 26'h2005000, 4'h5);
    give_verdict;
  end
endmodule
